// ===== pkg/rf_tag_pkg.sv
// Shared constants and state type of the transponder protocol sequencer
package rf_tag_pkg;
  // Clock and carrier timing
  localparam int SYS_PERIOD_NS     = 5;
  localparam int CARRIER_PERIOD_NS = 80;
  localparam int CARRIER_SYS_CYC   = CARRIER_PERIOD_NS / SYS_PERIOD_NS;
  localparam int GAP_W             = 5;
  localparam logic [GAP_W-1:0] GAP_LOSS =
    GAP_W'(CARRIER_SYS_CYC + CARRIER_SYS_CYC / 2 - 1);
  localparam logic [GAP_W-1:0] GAP_RELOAD = GAP_W'(CARRIER_SYS_CYC / 2);
  // Carrier-period counts
  localparam int POS_W = 8;
  localparam logic [POS_W-1:0] POS_ONE   = 8'h01;
  localparam logic [POS_W-1:0] BIT_TICKS = 8'h20;
  localparam logic [POS_W-1:0] BIT_LAST  = 8'h1f;
  localparam logic [POS_W-1:0] HALF_BIT  = 8'h10;
  localparam logic [POS_W-1:0] PATT_LAST = 8'h9f;
  localparam int SLOT_SHIFT = 4;
  localparam logic [9:0] LIW_MASK = 10'h003;
  localparam logic [9:0] NAK_MASK = 10'h0cc;
  // Frame lengths
  localparam int CMD_W         = 3;
  localparam int CMD_BITS      = 4;
  localparam int CHAL_BITS     = 56;
  localparam int DIV_BITS      = 7;
  localparam int LOCK_RSP_BITS = 28;
  localparam int TAG_RSP_BITS  = 20;
  localparam int AUTH_BITS     = CHAL_BITS + DIV_BITS + LOCK_RSP_BITS;
  localparam int RX_W          = 7;
  localparam logic [RX_W-1:0] RX_ONE    = 7'h01;
  localparam logic [RX_W-1:0] CMD_LAST  = 7'h03;
  localparam logic [RX_W-1:0] AUTH_LAST = 7'h5a;
  localparam int HDR_BITS = 16;
  localparam logic [HDR_BITS-1:0] HEADER = 16'hfff0;
  localparam int TX_BITS = 48;
  localparam int TX_W    = 6;
  localparam logic [TX_W-1:0] TX_ONE       = 6'h01;
  localparam logic [TX_W-1:0] TX_READ_LEN  = 6'h30;
  localparam logic [TX_W-1:0] TX_AUTH_LEN  = 6'h24;
  localparam int TX_PAD_BITS = TX_BITS - HDR_BITS - TAG_RSP_BITS;
  // Nonvolatile word map
  localparam int WORD_W    = 16;
  localparam int NVM_WORDS = 10;
  localparam int NVM_BITS  = NVM_WORDS * WORD_W;
  localparam int ADDR_W    = 4;
  localparam int W_UM_LO   = 0;
  localparam int W_UM_HI   = 1;
  localparam int W_ID_LO   = 2;
  localparam int W_ID_HI   = 3;
  localparam int W_KEY0    = 4;
  localparam int KEY_WORDS = 6;
  localparam int KEY_BITS  = KEY_WORDS * WORD_W;
  localparam int LOCK_UP_POS = 15;
  localparam int LOCK_LO_POS = 14;

  typedef enum logic [6:0] {
    ST_STANDBY = 7'h01,
    ST_RM2     = 7'h02,
    ST_CMD     = 7'h04,
    ST_AUTH_RX = 7'h08,
    ST_AUTH_WT = 7'h10,
    ST_TX      = 7'h20,
    ST_NAK     = 7'h40
  } seq_state_e;
endpackage : rf_tag_pkg

// ===== src/carrier_tick_gen.sv
// Carrier edge finder giving one tick per carrier period, bridging field gaps
`timescale 1ns/10ps
module carrier_tick_gen (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_carrier,
  output logic      o_tick,
  output logic      o_field_off
);
  import rf_tag_pkg::*;

  logic [2:0]       sync_ff;
  logic [GAP_W-1:0] gap_ff;
  logic             edge_seen;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], i_carrier};
    end
  end

  assign edge_seen = sync_ff[1] & ~sync_ff[2];

  // While the field is off, ticks keep coming at the nominal carrier rate
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      gap_ff      <= '0;
      o_tick      <= 1'b0;
      o_field_off <= 1'b0;
    end else if (edge_seen) begin
      gap_ff      <= '0;
      o_tick      <= 1'b1;
      o_field_off <= 1'b0;
    end else if (gap_ff == GAP_LOSS) begin
      gap_ff      <= GAP_RELOAD;
      o_tick      <= 1'b1;
      o_field_off <= 1'b1;
    end else begin
      gap_ff      <= gap_ff + 1'b1;
      o_tick      <= 1'b0;
    end
  end
endmodule : carrier_tick_gen

// ===== src/rf_tag_protocol_sequencer.sv
// Protocol sequencer of the contactless crypto transponder
`timescale 1ns/10ps
module rf_tag_protocol_sequencer #(
  parameter logic [rf_tag_pkg::CMD_W-1:0]    CMD_ID    = 3'h1,
  parameter logic [rf_tag_pkg::CMD_W-1:0]    CMD_UM    = 3'h2,
  parameter logic [rf_tag_pkg::CMD_W-1:0]    CMD_AUTH  = 3'h4,
  parameter logic [rf_tag_pkg::CMD_W-1:0]    CMD_WRITE = 3'h7,
  parameter logic [rf_tag_pkg::NVM_BITS-1:0] NVM_IMAGE = 160'h8000
) (
  input  wire logic                                 i_sys_clk,
  input  wire logic                                 i_rstn,
  input  wire logic                                 i_carrier,
  input  wire logic                                 i_auth_done,
  input  wire logic                                 i_auth_ok,
  input  wire logic [rf_tag_pkg::TAG_RSP_BITS-1:0]  i_tag_resp,
  input  wire logic                                 i_prog_en,
  input  wire logic [rf_tag_pkg::ADDR_W-1:0]        i_prog_addr,
  input  wire logic [rf_tag_pkg::WORD_W-1:0]        i_prog_data,
  output logic                                      o_modulator,
  output logic                                      o_standby,
  output logic                                      o_auth_req,
  output logic [rf_tag_pkg::CHAL_BITS-1:0]          o_challenge,
  output logic [rf_tag_pkg::LOCK_RSP_BITS-1:0]      o_lock_resp,
  output logic [rf_tag_pkg::KEY_BITS-1:0]           o_cipher_key,
  output logic                                      o_write_allowed
);
  import rf_tag_pkg::*;

  logic                  tick;
  logic                  field_off;
  seq_state_e            state_ff;
  logic [POS_W-1:0]      pos_ff;
  logic [RX_W-1:0]       rx_cnt_ff;
  logic                  zero_seen_ff;
  logic [AUTH_BITS-1:0]  rx_sh_ff;
  logic [AUTH_BITS-1:0]  nxt_rx_sh;
  logic [TX_BITS-1:0]    tx_sh_ff;
  logic [TX_W-1:0]       tx_cnt_ff;
  logic [WORD_W-1:0]     mem_ff [NVM_WORDS];
  logic                  bit_end;
  logic                  patt_end;
  logic                  patt_mode;
  logic                  rx_bit;
  logic                  detect;
  logic                  cmd_done;
  logic                  cmd_ok;
  logic [CMD_W-1:0]      cmd_code;
  logic                  go_id;
  logic                  go_um;
  logic                  auth_pass;
  logic [3:0]            slot;

  carrier_tick_gen u_tick (
    .i_sys_clk   (i_sys_clk),
    .i_rstn      (i_rstn),
    .i_carrier   (i_carrier),
    .o_tick      (tick),
    .o_field_off (field_off)
  );

  always_comb begin
    patt_mode = (state_ff == ST_STANDBY) || (state_ff == ST_NAK);
    bit_end   = tick && (pos_ff == BIT_LAST);
    patt_end  = tick && (pos_ff == PATT_LAST);
    slot      = 4'(pos_ff >> SLOT_SHIFT);
    rx_bit    = ~zero_seen_ff;
    nxt_rx_sh = {rx_sh_ff[AUTH_BITS-2:0], rx_bit};
    cmd_ok    = ~^nxt_rx_sh[CMD_BITS-1:0];
    cmd_code  = nxt_rx_sh[CMD_BITS-1:1];
    // Field gap seen during the modulated phase of a listen window
    detect    = (state_ff == ST_STANDBY) && field_off
                && (pos_ff < BIT_TICKS);
    cmd_done  = (state_ff == ST_CMD) && bit_end
                && (rx_cnt_ff == CMD_LAST);
    go_id     = cmd_done && cmd_ok && (cmd_code == CMD_ID);
    go_um     = cmd_done && cmd_ok && (cmd_code == CMD_UM);
    auth_pass = (state_ff == ST_AUTH_WT) && i_auth_done && i_auth_ok;
  end

  // Position in carrier periods within a pattern or a bit frame
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      pos_ff <= '0;
    end else if ((state_ff == ST_AUTH_WT) && i_auth_done) begin
      pos_ff <= '0;
    end else if (tick) begin
      if (patt_mode ? (pos_ff == PATT_LAST) : (pos_ff == BIT_LAST)) begin
        pos_ff <= '0;
      end else begin
        pos_ff <= pos_ff + POS_ONE;
      end
    end
  end

  // Sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_ff  <= ST_STANDBY;
      rx_cnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_STANDBY: begin
          rx_cnt_ff <= '0;
          if (detect) begin
            state_ff <= ST_RM2;
          end
        end
        ST_RM2: begin
          if (bit_end) begin
            if (rx_cnt_ff == '0) begin
              rx_cnt_ff <= RX_ONE;
            end else if (!rx_bit) begin
              state_ff  <= ST_CMD;
              rx_cnt_ff <= '0;
            end else begin
              state_ff <= ST_STANDBY;
            end
          end
        end
        ST_CMD: begin
          if (cmd_done) begin
            rx_cnt_ff <= '0;
            if (go_id || go_um) begin
              state_ff <= ST_TX;
            end else if (cmd_ok && (cmd_code == CMD_AUTH)) begin
              state_ff <= ST_AUTH_RX;
            end else if (cmd_ok && (cmd_code == CMD_WRITE)) begin
              // Write command is served elsewhere; it ends here too
              state_ff <= ST_STANDBY;
            end else begin
              state_ff <= ST_STANDBY;
            end
          end else if (bit_end) begin
            rx_cnt_ff <= rx_cnt_ff + RX_ONE;
          end
        end
        ST_AUTH_RX: begin
          if (bit_end) begin
            if (rx_cnt_ff == AUTH_LAST) begin
              state_ff <= ST_AUTH_WT;
            end else begin
              rx_cnt_ff <= rx_cnt_ff + RX_ONE;
            end
          end
        end
        ST_AUTH_WT: begin
          if (i_auth_done) begin
            state_ff <= i_auth_ok ? ST_TX : ST_NAK;
          end
        end
        ST_TX: begin
          if (bit_end && (tx_cnt_ff == TX_ONE)) begin
            state_ff <= ST_STANDBY;
          end
        end
        ST_NAK: begin
          if (patt_end) begin
            state_ff <= ST_STANDBY;
          end
        end
        default: begin
          state_ff <= ST_STANDBY;
        end
      endcase
    end
  end

  // Bit receiver: a field gap in the first half of a frame marks a zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      zero_seen_ff <= 1'b0;
      rx_sh_ff     <= '0;
    end else begin
      if (bit_end) begin
        zero_seen_ff <= 1'b0;
      end else if (field_off && (pos_ff < HALF_BIT)) begin
        zero_seen_ff <= 1'b1;
      end
      if (bit_end && ((state_ff == ST_CMD) || (state_ff == ST_AUTH_RX))) begin
        rx_sh_ff <= nxt_rx_sh;
      end
    end
  end

  // Challenge and lock response go to the cipher; divergency is dropped
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_auth_req  <= 1'b0;
      o_challenge <= '0;
      o_lock_resp <= '0;
    end else begin
      o_auth_req <= 1'b0;
      if ((state_ff == ST_AUTH_RX) && bit_end && (rx_cnt_ff == AUTH_LAST)) begin
        o_auth_req  <= 1'b1;
        o_challenge <= nxt_rx_sh[AUTH_BITS-1 -: CHAL_BITS];
        o_lock_resp <= nxt_rx_sh[LOCK_RSP_BITS-1:0];
      end
    end
  end

  // Transmit shifter: header then payload, MSB first
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      tx_sh_ff  <= '0;
      tx_cnt_ff <= '0;
    end else if (go_id) begin
      tx_sh_ff  <= {HEADER, mem_ff[W_ID_HI], mem_ff[W_ID_LO]};
      tx_cnt_ff <= TX_READ_LEN;
    end else if (go_um) begin
      tx_sh_ff  <= {HEADER, mem_ff[W_UM_HI], mem_ff[W_UM_LO]};
      tx_cnt_ff <= TX_READ_LEN;
    end else if (auth_pass) begin
      tx_sh_ff  <= {HEADER, i_tag_resp, {TX_PAD_BITS{1'b0}}};
      tx_cnt_ff <= TX_AUTH_LEN;
    end else if ((state_ff == ST_TX) && bit_end) begin
      tx_sh_ff  <= {tx_sh_ff[TX_BITS-2:0], 1'b0};
      tx_cnt_ff <= tx_cnt_ff - TX_ONE;
    end
  end

  // Load modulator drive
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_modulator <= 1'b0;
    end else begin
      case (state_ff)
        ST_STANDBY: begin
          o_modulator <= detect ? 1'b0 : LIW_MASK[slot];
        end
        ST_RM2: begin
          o_modulator <= (rx_cnt_ff != '0) && (pos_ff < HALF_BIT);
        end
        ST_CMD, ST_AUTH_RX: begin
          o_modulator <= pos_ff < HALF_BIT;
        end
        ST_TX: begin
          // First half carries the inverse, second half the bit value
          o_modulator <= (pos_ff < HALF_BIT) ? ~tx_sh_ff[TX_BITS-1]
                                             : tx_sh_ff[TX_BITS-1];
        end
        ST_NAK: begin
          o_modulator <= NAK_MASK[slot];
        end
        default: begin
          o_modulator <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_standby       <= 1'b0;
      o_write_allowed <= 1'b0;
    end else begin
      o_standby       <= state_ff == ST_STANDBY;
      o_write_allowed <= mem_ff[W_UM_HI][LOCK_UP_POS]
                         & ~mem_ff[W_UM_HI][LOCK_LO_POS];
    end
  end

  // Word store; identity words take no writes, key words only feed the cipher
  for (genvar w = 0; w < NVM_WORDS; w++) begin : g_word
    always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
        mem_ff[w] <= NVM_IMAGE[w*WORD_W +: WORD_W];
      end else if (i_prog_en && o_write_allowed
                   && (i_prog_addr == ADDR_W'(w))
                   && (w != W_ID_LO) && (w != W_ID_HI)) begin
        mem_ff[w] <= i_prog_data;
      end
    end
    if (w >= W_KEY0) begin : g_key
      assign o_cipher_key[(w-W_KEY0)*WORD_W +: WORD_W] = mem_ff[w];
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_auth_reject;
    (state_ff == ST_AUTH_WT) && i_auth_done && !i_auth_ok;
  endsequence
  sequence s_nak_start;
    (state_ff == ST_NAK) && (pos_ff == '0);
  endsequence
  sequence s_tx_last;
    (state_ff == ST_TX) && bit_end && (tx_cnt_ff == TX_ONE);
  endsequence

  property p_reset_standby;
    $rose(i_rstn) |-> (state_ff == ST_STANDBY) ##1 o_standby;
  endproperty
  a_reset_standby: assert property (p_reset_standby)
    else $error("not in standby after reset");

  property p_liw_wrap;
    (state_ff == ST_STANDBY) && patt_end && !detect |=> (pos_ff == '0);
  endproperty
  a_liw_wrap: assert property (p_liw_wrap)
    else $error("listen window length wrong");

  property p_liw_mod;
    (state_ff == ST_STANDBY) && !detect |=> (o_modulator == LIW_MASK[$past(slot)]);
  endproperty
  a_liw_mod: assert property (p_liw_mod)
    else $error("listen window drive wrong");

  property p_stop_mod;
    detect |=> !o_modulator && (state_ff == ST_RM2);
  endproperty
  a_stop_mod: assert property (p_stop_mod)
    else $error("modulator not stopped on entry pattern");

  property p_parity_abort;
    cmd_done && !cmd_ok |=> (state_ff == ST_STANDBY);
  endproperty
  a_parity_abort: assert property (p_parity_abort)
    else $error("parity error not aborted");

  property p_tx_return;
    s_tx_last |=> (state_ff == ST_STANDBY) ##1 o_standby;
  endproperty
  a_tx_return: assert property (p_tx_return)
    else $error("no standby after transmit");

  property p_header;
    go_id |=> (tx_sh_ff[TX_BITS-1 -: HDR_BITS] == HEADER) && (tx_cnt_ff == TX_READ_LEN);
  endproperty
  a_header: assert property (p_header)
    else $error("header not loaded");

  property p_nak;
    s_auth_reject |=> s_nak_start;
  endproperty
  a_nak: assert property (p_nak)
    else $error("rejected lock response without not-acknowledge");

  property p_rx_frame;
    ((state_ff == ST_CMD) || (state_ff == ST_AUTH_RX)) && (pos_ff == HALF_BIT) |=> !o_modulator;
  endproperty
  a_rx_frame: assert property (p_rx_frame)
    else $error("modulator not off at half frame");

  property p_rx_on;
    (state_ff == ST_CMD) && (pos_ff == '0) |=> o_modulator;
  endproperty
  a_rx_on: assert property (p_rx_on)
    else $error("modulator not on at frame start");

  property p_write_lock;
    i_prog_en && !o_write_allowed |=> $stable(mem_ff[W_UM_LO]) && $stable(mem_ff[W_UM_HI]);
  endproperty
  a_write_lock: assert property (p_write_lock)
    else $error("write while locked");

  property p_id_const;
    i_prog_en |=> $stable(mem_ff[W_ID_LO]) && $stable(mem_ff[W_ID_HI]);
  endproperty
  a_id_const: assert property (p_id_const)
    else $error("identity word changed");
endmodule : rf_tag_protocol_sequencer

// ===== tb/rf_reader_model.sv
// Reader model: free-running carrier, gap-coded downlink bits, uplink sampling
`timescale 1ns/10ps
module rf_reader_model (
  input  wire logic i_modulator,
  output logic      o_carrier
);
  int   per     = 0;
  int   gap_lo  = 0;
  int   gap_hi  = 0;
  int   base    = 0;
  logic stop_ok = 1'b1;
  logic rx_ok   = 1'b1;
  logic man_ok  = 1'b1;

  // Field runs free; phase unrelated to the system clock
  initial begin
    o_carrier = 1'b0;
    #13;
    forever begin
      per = per + 1;
      o_carrier = !(per >= gap_lo && per < gap_hi);
      #40;
      o_carrier = 1'b0;
      #40;
    end
  end

  task automatic at_slot(input int s);
    while (per < s) @(per);
    #20;
  endtask : at_slot

  // Bits go MSB first; frame 0 is aligned to a listen window start
  task automatic send_bits(input logic [127:0] bits, input int n);
    int f;
    @(posedge i_modulator);
    base = per;
    for (int k = 0; k < n; k++) begin
      f = base + 32 * k;
      gap_lo = bits[n-1-k] ? 0 : f + 4;
      gap_hi = bits[n-1-k] ? 0 : f + 16;
      at_slot(f + 8);
      if (k > 0) rx_ok = rx_ok & i_modulator;
      at_slot(f + 24);
      if (k == 0) stop_ok = stop_ok & !i_modulator;
      else rx_ok = rx_ok & !i_modulator;
    end
    at_slot(base + 32 * n);
  endtask : send_bits

  // First sent bit is a one, so the modulator rises mid-frame
  task automatic rx_bits(input int n, output logic [63:0] d);
    logic a;
    d = '0;
    @(posedge i_modulator);
    base = per - 16;
    for (int k = 0; k < n; k++) begin
      at_slot(base + 32 * k + 8);
      a = (k == 0) ? 1'b0 : i_modulator;
      at_slot(base + 32 * k + 24);
      man_ok = man_ok & (a != i_modulator);
      d = {d[62:0], i_modulator};
    end
  endtask : rx_bits

  // Samples mid-slot through a refusal pattern and into the next window
  task automatic nak_pattern(output logic [5:0] s);
    base = per;
    for (int k = 0; k < 6; k++) begin
      at_slot(base + 16 + 32 * k);
      s = {s[4:0], i_modulator};
    end
  endtask : nak_pattern
endmodule : rf_reader_model

// ===== tb/rf_tag_protocol_sequencer_test.sv
// Self-checking bench of the transponder protocol sequencer
`timescale 1ns/10ps
module rf_tag_protocol_sequencer_test;
  import rf_tag_pkg::*;
  localparam logic [2:0]          CODE_ID   = 3'h3;
  localparam logic [2:0]          CODE_USER = 3'h5;
  localparam logic [2:0]          CODE_AU   = 3'h6;
  localparam logic [2:0]          CODE_WR   = 3'h1;
  localparam logic [15:0]         W0        = 16'h5a3c;
  localparam logic [15:0]         W1        = 16'h8e71;
  localparam logic [15:0]         W2        = 16'hc3a5;
  localparam logic [15:0]         W3        = 16'h6b1d;
  localparam logic [NVM_BITS-1:0] IMG       = {96'h0f1e2d3c4b5a69788796a5b4, W3, W2, W1, W0};
  localparam logic [55:0]         CHAL      = 56'h13579bdf2468ac;
  localparam logic [27:0]         LRSP      = 28'h9abcdef;

  logic                     i_sys_clk;
  logic                     i_rstn;
  logic                     i_auth_done;
  logic                     i_auth_ok;
  logic [TAG_RSP_BITS-1:0]  i_tag_resp;
  logic                     i_prog_en;
  logic [ADDR_W-1:0]        i_prog_addr;
  logic [WORD_W-1:0]        i_prog_data;
  logic                     carrier;
  logic                     o_modulator;
  logic                     o_standby;
  logic                     o_auth_req;
  logic [CHAL_BITS-1:0]     o_challenge;
  logic [LOCK_RSP_BITS-1:0] o_lock_resp;
  logic [KEY_BITS-1:0]      o_cipher_key;
  logic                     o_write_allowed;
  int                       n_mismatch = 0;
  int                       n_checks   = 0;

  rf_tag_protocol_sequencer #(
    .CMD_ID(CODE_ID), .CMD_UM(CODE_USER), .CMD_AUTH(CODE_AU), .CMD_WRITE(CODE_WR), .NVM_IMAGE(IMG)
  ) i_rf_tag_protocol_sequencer (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_carrier(carrier), .i_auth_done(i_auth_done),
    .i_auth_ok(i_auth_ok), .i_tag_resp(i_tag_resp), .i_prog_en(i_prog_en), .i_prog_addr(i_prog_addr),
    .i_prog_data(i_prog_data), .o_modulator(o_modulator), .o_standby(o_standby), .o_auth_req(o_auth_req),
    .o_challenge(o_challenge), .o_lock_resp(o_lock_resp), .o_cipher_key(o_cipher_key),
    .o_write_allowed(o_write_allowed)
  );

  rf_reader_model i_rf_reader_model (.i_modulator(o_modulator), .o_carrier(carrier));

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic wait_standby();
    for (int i = 0; i < 3000 && o_standby !== 1'b1; i++) @(posedge i_sys_clk);
  endtask : wait_standby

  task automatic prog(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(negedge i_sys_clk);
    i_prog_en = 1'b1;
    i_prog_addr = a;
    i_prog_data = d;
    @(negedge i_sys_clk);
    i_prog_en = 1'b0;
  endtask : prog

  task automatic t_reset();
    @(negedge i_sys_clk);
    i_rstn = 1'b0;
    repeat (12) @(negedge i_sys_clk);
    check("standby_in_reset", o_standby, 1'b0);
    check("mod_in_reset", o_modulator, 1'b0);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    check("standby", o_standby, 1'b1);
    check("write_allowed", o_write_allowed, 1'b1);
    check("key", o_cipher_key, IMG[159:64]);
  endtask : t_reset

  task automatic t_listen_window();
    int t0;
    int t1;
    @(posedge o_modulator);
    t0 = i_rf_reader_model.per;
    @(negedge o_modulator);
    t1 = i_rf_reader_model.per;
    check("window_on", t1 - t0, 32);
    @(posedge o_modulator);
    t1 = i_rf_reader_model.per;
    check("window_len", t1 - t0, 160);
  endtask : t_listen_window

  task automatic t_prog();
    prog(4'h4, 16'habcd);
    check("key_word4", o_cipher_key[15:0], 16'habcd);
    // Identity word must stay as imaged; the read below shows it
    prog(4'h2, 16'h0000);
    prog(4'h0, 16'h0f0f);
    prog(4'h1, 16'h0e71);
    @(negedge i_sys_clk);
    check("write_locked", o_write_allowed, 1'b0);
    prog(4'h4, 16'h1357);
    check("key_locked", o_cipher_key[15:0], 16'habcd);
  endtask : t_prog

  task automatic t_read(input logic [2:0] c, input int n, input logic [63:0] exp, input bit back);
    logic [63:0] d;
    wait_standby();
    i_rf_reader_model.send_bits({122'h0, 2'b00, c, ^c}, 6);
    check("stop_on_entry", i_rf_reader_model.stop_ok, 1'b1);
    check("rx_frames", i_rf_reader_model.rx_ok, 1'b1);
    check("busy", o_standby, 1'b0);
    i_rf_reader_model.rx_bits(n, d);
    check("uplink", d, exp);
    check("manchester", i_rf_reader_model.man_ok, 1'b1);
    if (back) begin
      #1300;
      check("standby_after_read", o_standby, 1'b1);
    end
  endtask : t_read

  task automatic t_bad_cmd();
    logic [3:0] cb;
    for (int k = 0; k < 3; k++) begin
      cb = (k == 0) ? {CODE_ID, !(^CODE_ID)} : (k == 1) ? 4'h5 : {CODE_WR, ^CODE_WR};
      wait_standby();
      i_rf_reader_model.send_bits({122'h0, 2'b00, cb}, 6);
      #100;
      check("standby_after_bad", o_standby, 1'b1);
    end
  endtask : t_bad_cmd

  task automatic t_auth(input bit ok);
    logic [5:0]               s;
    logic [63:0]              d;
    logic [CHAL_BITS-1:0]     ch;
    logic [LOCK_RSP_BITS-1:0] lr;
    wait_standby();
    fork
      i_rf_reader_model.send_bits({31'h0, 2'b00, CODE_AU, ^CODE_AU, CHAL, 7'h00, LRSP}, 97);
      begin
        @(posedge i_sys_clk iff o_auth_req === 1'b1);
        #1;
        ch = o_challenge;
        lr = o_lock_resp;
      end
    join
    check("challenge", ch, CHAL);
    check("lock_resp", lr, LRSP);
    @(negedge i_sys_clk);
    i_auth_done = 1'b1;
    i_auth_ok = ok;
    @(negedge i_sys_clk);
    i_auth_done = 1'b0;
    if (ok) begin
      i_rf_reader_model.rx_bits(36, d);
      check("tag_resp", d, {28'h0, HEADER, 20'h5a5a5});
      check("manchester_auth", i_rf_reader_model.man_ok, 1'b1);
      #1300;
      check("standby_after_tag", o_standby, 1'b1);
    end else begin
      i_rf_reader_model.nak_pattern(s);
      check("nak_then_window", s, 6'b010101);
      check("standby_after_auth", o_standby, 1'b1);
    end
  endtask : t_auth

  initial begin
    #1600000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    i_rstn = 1'b0;
    i_auth_done = 1'b0;
    i_auth_ok = 1'b0;
    i_tag_resp = 20'h5a5a5;
    i_prog_en = 1'b0;
    i_prog_addr = 4'h0;
    i_prog_data = 16'h0000;
    t_reset();
    t_listen_window();
    t_prog();
    t_read(CODE_ID, 48, {16'h0, HEADER, W3, W2}, 1'b1);
    t_bad_cmd();
    t_read(CODE_USER, 48, {16'h0, HEADER, 16'h0e71, 16'h0f0f}, 1'b0);
    t_reset();
    t_auth(1'b1);
    t_auth(1'b0);
    wrap_up();
  end
endmodule : rf_tag_protocol_sequencer_test
